// ===== hw/bee_regs.svh
// timing constants and pin levels for the byte eeprom programming controller
`ifndef BEE_REGS_SVH
`define BEE_REGS_SVH
`define BEE_CLK_PERIOD_NS   20
`define BEE_ADDR_W          11
`define BEE_DATA_W          8
`define BEE_ERASED_BYTE     8'hFF
// program pulse: least 9 ms, longest 15 ms, aim at 10 ms
`define BEE_PULSE_MIN_NS    9000000
`define BEE_PULSE_MAX_NS    15000000
`define BEE_PULSE_NOM_NS    10000000
// deselect gap before each programming cycle
`define BEE_GAP_NS          1000
// read access time (slowest grade) and output float time
`define BEE_ACCESS_NS       450
`define BEE_FLOAT_NS        100
// set-up of address and select before the program pulse, and hold after it
`define BEE_SETUP_NS        150
`define BEE_HOLD_NS         50
`define BEE_CHIP_ERASE_NS   10000000
`endif

// ===== hw/bee_pkg.sv
// types for the byte eeprom programming controller
package bee_pkg;
  typedef enum logic [1:0] {
    BEE_OP_READ  = 2'h0,
    BEE_OP_WRITE = 2'h1,
    BEE_OP_ERASE = 2'h2,
    BEE_OP_CHIP  = 2'h3
  } bee_op_t;

  typedef enum logic [6:0] {
    BEE_IDLE   = 7'h01,
    BEE_GAP    = 7'h02,
    BEE_SETUP  = 7'h04,
    BEE_PULSE  = 7'h08,
    BEE_HOLD   = 7'h10,
    BEE_ACCESS = 7'h20,
    BEE_FLOAT  = 7'h40
  } bee_state_t;
endpackage : bee_pkg

// ===== hw/bee_timer.sv
// down counter that times each phase of a pin sequence
`timescale 1ns/100ps
module bee_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [19:0] count,
  output logic             done
);
  logic [19:0] cnt_q;

  // load a cycle count; done is high once it has run out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 20'h00000;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != 20'h00000) begin
      cnt_q <= cnt_q - 20'h00001;
    end
  end

  // done only looks at the count: the caller raises load from done, so mixing
  // load back in here would close a combinational loop
  assign done = (cnt_q == 20'h00000);
endmodule : bee_timer

// ===== hw/bee_ctrl.sv
// controller that reads, erases and writes a 2k byte eeprom through its pins
// Overview of operation
// - read data only with select and gate low
// - chip erase: gate high voltage, write condition
// - erase a byte before writing it
// - byte erase: ones on data, select low, program
// - gate held high during byte erase, write
// - program pulse between 9 and 15 ms
// - write repeats pulse with stored byte
// - select falls to start; gap high between
// - select from decode, gate from read strobe
// - deselect gap is at least 1 us
// - program level only during erase, write
`timescale 1ns/100ps
`include "bee_regs.svh"
module bee_ctrl #(
  parameter int unsigned PULSE_CYCLES = (`BEE_PULSE_NOM_NS) / `BEE_CLK_PERIOD_NS
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire bee_pkg::bee_op_t        req_op,
  input  wire logic [`BEE_ADDR_W-1:0]  req_addr,
  input  wire logic [`BEE_DATA_W-1:0]  req_wdata,
  output logic                         rsp_valid,
  output logic [`BEE_DATA_W-1:0]       rsp_rdata,
  output logic [`BEE_ADDR_W-1:0]       mem_addr,
  output logic                         mem_select_n,
  output logic                         mem_gate_n,
  output logic                         mem_gate_hv,
  output logic                         mem_program,
  input  wire logic [`BEE_DATA_W-1:0]  mem_data_in,
  output logic [`BEE_DATA_W-1:0]       mem_data_out,
  output logic                         mem_data_oe
);
  // cycle counts; least times round up, the pulse aim sits inside 9..15 ms
  localparam int unsigned GAP_CYC   = (`BEE_GAP_NS + `BEE_CLK_PERIOD_NS - 1) / `BEE_CLK_PERIOD_NS;
  localparam int unsigned ACC_CYC   = (`BEE_ACCESS_NS + `BEE_CLK_PERIOD_NS - 1)
                                      / `BEE_CLK_PERIOD_NS;
  localparam int unsigned FLT_CYC   = (`BEE_FLOAT_NS + `BEE_CLK_PERIOD_NS - 1) / `BEE_CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC = (`BEE_SETUP_NS + `BEE_CLK_PERIOD_NS - 1)
                                      / `BEE_CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC  = (`BEE_HOLD_NS + `BEE_CLK_PERIOD_NS - 1) / `BEE_CLK_PERIOD_NS;

  bee_pkg::bee_state_t        state_q;
  bee_pkg::bee_op_t           op_q;
  logic [`BEE_ADDR_W-1:0]     addr_q;
  logic [`BEE_DATA_W-1:0]     wdata_q;
  logic [`BEE_DATA_W-1:0]     rdata_q;
  logic                       rsp_q;
  logic                       tmr_load;
  logic [19:0]                tmr_count;
  logic                       tmr_done;

  // counts are wider than needed for the gap, fine for a 15 ms pulse
  function automatic logic [19:0] cyc20(input int unsigned n);
    cyc20 = n[19:0] - 20'h00001;
  endfunction : cyc20

  bee_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  assign req_ready = (state_q == bee_pkg::BEE_IDLE);

  // timer reloads on every state entry except the return to idle
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = 20'h00000;
    case (state_q)
      bee_pkg::BEE_IDLE: begin
        if (req_valid) begin
          tmr_load  = 1'b1;
          // programming always starts from a deselect gap so select falls fresh
          tmr_count = (req_op == bee_pkg::BEE_OP_READ) ? cyc20(ACC_CYC) : cyc20(GAP_CYC);
        end
      end
      bee_pkg::BEE_GAP: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = cyc20(SETUP_CYC);
        end
      end
      bee_pkg::BEE_SETUP: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = cyc20(PULSE_CYCLES);
        end
      end
      bee_pkg::BEE_PULSE: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = cyc20(HOLD_CYC);
        end
      end
      bee_pkg::BEE_ACCESS: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_count = cyc20(FLT_CYC);
        end
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_count = 20'h00000;
      end
    endcase
  end

  // sequencer: read is one select+gate window, program ops are gap/setup/pulse/hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= bee_pkg::BEE_IDLE;
    end else begin
      case (state_q)
        bee_pkg::BEE_IDLE: begin
          if (req_valid) begin
            state_q <= (req_op == bee_pkg::BEE_OP_READ) ? bee_pkg::BEE_ACCESS : bee_pkg::BEE_GAP;
          end
        end
        bee_pkg::BEE_GAP:    if (tmr_done) state_q <= bee_pkg::BEE_SETUP;
        bee_pkg::BEE_SETUP:  if (tmr_done) state_q <= bee_pkg::BEE_PULSE;
        bee_pkg::BEE_PULSE:  if (tmr_done) state_q <= bee_pkg::BEE_HOLD;
        bee_pkg::BEE_HOLD:   if (tmr_done) state_q <= bee_pkg::BEE_IDLE;
        bee_pkg::BEE_ACCESS: if (tmr_done) state_q <= bee_pkg::BEE_FLOAT;
        bee_pkg::BEE_FLOAT:  if (tmr_done) state_q <= bee_pkg::BEE_IDLE;
        default:             state_q <= bee_pkg::BEE_IDLE;
      endcase
    end
  end

  // request capture; erase forces ones on the data bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_q    <= bee_pkg::BEE_OP_READ;
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (req_valid && req_ready) begin
      op_q    <= req_op;
      addr_q  <= req_addr;
      wdata_q <= (req_op == bee_pkg::BEE_OP_ERASE) ? `BEE_ERASED_BYTE : req_wdata;
    end
  end

  // sample read data at the end of the access window, after the worst access time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      if (state_q == bee_pkg::BEE_ACCESS && tmr_done) begin
        rdata_q <= mem_data_in;
        rsp_q   <= 1'b1;
      end else if (state_q == bee_pkg::BEE_HOLD && tmr_done) begin
        rsp_q   <= 1'b1;
      end
    end
  end

  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign mem_addr  = addr_q;

  // pin drive; select stays high in idle and gap for standby
  always_comb begin
    mem_select_n = 1'b1;
    mem_gate_n   = 1'b1;
    mem_gate_hv  = 1'b0;
    mem_program  = 1'b0;
    mem_data_oe  = 1'b0;
    case (state_q)
      bee_pkg::BEE_SETUP, bee_pkg::BEE_PULSE, bee_pkg::BEE_HOLD: begin
        mem_select_n = 1'b0;
        // drive data unless chip erase, where the device ignores it
        mem_data_oe  = (op_q != bee_pkg::BEE_OP_CHIP);
        mem_gate_hv  = (op_q == bee_pkg::BEE_OP_CHIP);
        mem_program  = (state_q == bee_pkg::BEE_PULSE);
      end
      bee_pkg::BEE_ACCESS: begin
        mem_select_n = 1'b0;
        mem_gate_n   = 1'b0;
      end
      default: begin
        mem_select_n = 1'b1;
      end
    endcase
  end

  assign mem_data_out = wdata_q;

  // helper: length of the current program pulse in cycles
  logic [19:0] pulse_len_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_len_q <= 20'h00000;
    end else if (mem_program) begin
      pulse_len_q <= pulse_len_q + 20'h00001;
    end else begin
      pulse_len_q <= 20'h00000;
    end
  end

  // pulse limits scale with the pulse aim, so a shortened pulse keeps the 9:10:15 ratio
  localparam logic [19:0] PULSE_MIN_CYC =
    20'(PULSE_CYCLES * (`BEE_PULSE_MIN_NS / 1000000) / (`BEE_PULSE_NOM_NS / 1000000));
  localparam logic [19:0] PULSE_MAX_CYC =
    20'(PULSE_CYCLES * (`BEE_PULSE_MAX_NS / 1000000) / (`BEE_PULSE_NOM_NS / 1000000));
  localparam logic [7:0]  GAP_MIN_CNT   = 8'(GAP_CYC - 1);

  // helper: cycles spent deselected, saturating so a long idle cannot wrap
  logic [7:0] desel_cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      desel_cnt_q <= 8'h00;
    end else if (!mem_select_n) begin
      desel_cnt_q <= 8'h00;
    end else if (desel_cnt_q != 8'hFF) begin
      desel_cnt_q <= desel_cnt_q + 8'h01;
    end
  end

  // select falling into the program set-up phase opens a programming cycle
  sequence program_start_seq;
    $fell(mem_select_n) && (state_q == bee_pkg::BEE_SETUP);
  endsequence

  gate_high_prog_a: assert property (@(posedge clk) disable iff (rst)
    mem_program |-> mem_gate_n)
    else $error("gate low during program pulse");
  pulse_max_a: assert property (@(posedge clk) disable iff (rst)
    pulse_len_q <= PULSE_MAX_CYC) else $error("program pulse too long");
  pulse_min_a: assert property (@(posedge clk) disable iff (rst)
    $fell(mem_program) |-> $past(pulse_len_q) >= (PULSE_MIN_CYC - 20'h00001))
    else $error("program pulse too short");
  gap_before_a: assert property (@(posedge clk) disable iff (rst)
    program_start_seq |-> $past(desel_cnt_q) >= GAP_MIN_CNT)
    else $error("deselect gap too short");
  select_prog_a: assert property (@(posedge clk) disable iff (rst)
    mem_program |-> !mem_select_n) else $error("program without select");
  erase_ones_a: assert property (@(posedge clk) disable iff (rst)
    mem_data_oe && op_q == bee_pkg::BEE_OP_ERASE |-> mem_data_out == 8'hFF)
    else $error("erase data not all ones");
  read_gate_a: assert property (@(posedge clk) disable iff (rst)
    !mem_gate_n |-> !mem_select_n && !mem_data_oe) else $error("gate low outside read");
  hv_only_chip_a: assert property (@(posedge clk) disable iff (rst)
    mem_gate_hv |-> op_q == bee_pkg::BEE_OP_CHIP && !mem_select_n)
    else $error("gate high voltage outside chip erase");
endmodule : bee_ctrl

// ===== tb/bee_mem_model.sv
// behavioural model of the 2k byte eeprom seen through its pins
`timescale 1ns/100ps
module bee_mem_model #(
  parameter int ACC_CYC = 22,
  parameter int GAP_CYC = 50,
  parameter int PMIN    = 180,
  parameter int PMAX    = 300
) (
  input  wire logic        clk,
  input  wire logic [10:0] addr,
  input  wire logic        select_n,
  input  wire logic        gate_n,
  input  wire logic        gate_hv,
  input  wire logic        prog_pulse,
  input  wire logic [7:0]  din,
  input  wire logic        din_oe,
  output logic [7:0]       dout,
  output int               faults
);
  logic [7:0]  mem [2048];
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  din_q;
  logic [10:0] a_q, pa_q;
  logic        hv_q, oe_q;
  logic        rd_on;
  int          acc = 0;
  int          gap = 0;
  int          last_gap = 0;
  int          plen = 0;
  initial faults = 0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  assign rd_on = !select_n && !gate_n;
  // before the access time the bus shows a toggling pattern, never a stale value
  always_comb dout = (rd_on && acc >= ACC_CYC) ? mem[addr] : ~last_q;
  // access timer counts whole cycles since select and gate both went low or the last address move
  always @(posedge clk) begin
    a_q <= addr;
    last_q <= dout;
    acc <= (rd_on === 1'b1) ? ((addr == a_q) ? acc + 1 : 1) : 0;
  end
  // program sequencing checks; unknown pins before reset settles count as no pulse, and an unknown select restarts the gap
  always @(posedge clk) begin
    gap <= (select_n === 1'b1) ? gap + 1 : 0;
    if (!select_n && gap != 0) last_gap <= gap;
    plen <= (prog_pulse === 1'b1) ? plen + 1 : 0;
    if (din_oe && rd_on) faults <= faults + 1;
    if (prog_pulse && select_n) faults <= faults + 1;
    if (prog_pulse && plen == 0 && (gate_n !== 1'b1 || last_gap < GAP_CYC))
      faults <= faults + 1;
    if (prog_pulse) begin
      hv_q <= gate_hv;
      oe_q <= din_oe;
      din_q <= din;
      pa_q <= addr;
    end
    if (!prog_pulse && plen != 0) begin
      if (plen < PMIN || plen > PMAX) faults <= faults + 1;
      if (hv_q) begin
        foreach (mem[i]) mem[i] <= 8'hFF;
      end else if (!oe_q) begin
        faults <= faults + 1;
      end else begin
        if (din_q != 8'hFF && mem[pa_q] != 8'hFF) faults <= faults + 1;
        mem[pa_q] <= din_q;
      end
    end
  end
endmodule : bee_mem_model

// ===== tb/bee_tb_top.sv
// self-checking bench for the byte eeprom programming controller
`timescale 1ns/100ps
module byte_eeprom_erase_write_port_tb_top;
  logic             clk, rst, req_valid, req_ready, rsp_valid;
  logic             sel_n, gate_n, hv, prog, oe;
  bee_pkg::bee_op_t req_op;
  logic [10:0]      req_addr, mem_addr;
  logic [7:0]       req_wdata, rsp_rdata, dout, din, rd;
  int               faults;
  int               mismatches = 0;
  int               checks = 0;
  int               cyc = 0;
  // short pulse keeps the run brief; model limits 180 and 300 are fixed at 9:10:15 of it
  bee_ctrl #(.PULSE_CYCLES(200)) dut (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
    .mem_select_n(sel_n), .mem_gate_n(gate_n), .mem_gate_hv(hv), .mem_program(prog),
    .mem_data_in(din), .mem_data_out(dout), .mem_data_oe(oe));
  bee_mem_model mem (.clk(clk), .addr(mem_addr), .select_n(sel_n), .gate_n(gate_n),
    .gate_hv(hv), .prog_pulse(prog), .din(dout), .din_oe(oe), .dout(din), .faults(faults));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  // one request held until taken, then a bounded wait for its answer
  task automatic do_op(input bee_pkg::bee_op_t op, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, rsp_valid}, 8'h01, "answer");
    rd = rsp_rdata;
  endtask : do_op
  task automatic t_idle;
    @(negedge clk);
    check({4'h0, sel_n, gate_n, prog, oe}, 8'h0C, "idle pins");
    check({7'h00, hv}, 8'h00, "idle hv");
    $display("test idle done");
  endtask : t_idle
  task automatic t_chip;
    do_op(bee_pkg::BEE_OP_CHIP, 11'h000, 8'h00);
    do_op(bee_pkg::BEE_OP_READ, 11'h000, 8'h00);
    check(rd, 8'hFF, "first byte");
    do_op(bee_pkg::BEE_OP_READ, 11'h7FF, 8'h00);
    check(rd, 8'hFF, "last byte");
    $display("test chip erase done");
  endtask : t_chip
  task automatic t_bytes;
    do_op(bee_pkg::BEE_OP_ERASE, 11'h400, 8'h00);
    do_op(bee_pkg::BEE_OP_WRITE, 11'h400, 8'h5A);
    do_op(bee_pkg::BEE_OP_ERASE, 11'h401, 8'h00);
    do_op(bee_pkg::BEE_OP_WRITE, 11'h401, 8'hA5);
    do_op(bee_pkg::BEE_OP_READ, 11'h400, 8'h00);
    check(rd, 8'h5A, "written byte");
    do_op(bee_pkg::BEE_OP_ERASE, 11'h400, 8'h00);
    do_op(bee_pkg::BEE_OP_READ, 11'h400, 8'h00);
    check(rd, 8'hFF, "erased byte");
    do_op(bee_pkg::BEE_OP_READ, 11'h401, 8'h00);
    check(rd, 8'hA5, "neighbour");
    $display("test byte program done");
  endtask : t_bytes
  task automatic t_faults;
    checks++;
    if (faults != 0) begin
      mismatches++;
      $display("wrong value at %0t: %0d pin sequence faults", $time, faults);
    end
    $display("test pin sequencing done");
  endtask : t_faults
  // hang guard well above the under two thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("wrong value at %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = bee_pkg::BEE_OP_READ;
    req_addr = 11'h000;
    req_wdata = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_idle();
    t_chip();
    t_bytes();
    t_faults();
    give_verdict();
  end
endmodule : byte_eeprom_erase_write_port_tb_top
